//--- design/dual_display_sync_splitter.sv
// splits one raster timing stream between a master and an auxiliary display
//
// What this block does
// - no split: all 31 lines on one screen
// - split: 15 lines each, one switching slot
// - sequencing from timing signals alone, mode from the control register
// - normal vertical sync every 31 lines
// - vertical sync clears counter, selects a, arms syncs
// - sync leads video by eight, envelope 15 lines
// - count eight with odd field, or any field non-interlaced: sync to b
// - count sixteen with bit one: b video
// - count sixteen plus eight: sync to a
// - every further 16 counts sync alternates a/b
// - next vertical sync returns video to a
// - frame decode with odd field restarts frame
// - horizontal sync inverted and sent to both
// - video gated by selected screen enable
// - interlace default, non-interlace halves the lines when split
// - picture complete after odd and even field
`timescale 1ns/10ps
module dual_display_sync_splitter
    import dds_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    // register bus
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // from the raster timing unit
    input wire logic hsync_in,
    input wire logic vsync_in_n,
    input wire logic video_in,
    input wire logic odd_field,
    input wire logic frame_count_decode,
    input wire logic seg_reset_sync,
    input wire logic seg_reset_toggle,
    // to the displays
    output logic hsync_out_a,
    output logic hsync_out_b,
    output logic vsync_out_a,
    output logic vsync_out_b,
    output logic video_out_a,
    output logic video_out_b,
    output logic picture_done
);
    localparam int NPIN = 7;

    logic [NPIN-1:0] pins;
    logic [NPIN-1:0] lvl;
    logic h_s;
    logic vn_s;
    logic vid_s;
    logic odd_s;
    logic frm_s;
    logic segs_s;
    logic segt_s;

    logic split_en;
    logic interlace_en;
    logic [31:0] status;

    logic h_prev_q;
    logic vn_prev_q;
    logic line_stb;
    logic vs_fall;

    logic [CNT_W-1:0] line_cnt_q;
    logic sel_b_q;
    logic arm_a_q;
    logic arm_b_q;
    logic next_b_q;
    logic field_odd_q;
    logic [7:0] frames_q;

    logic sync_slot;
    logic fire_a;
    logic fire_b;
    logic toggle_hit;
    logic env_a;
    logic env_b;
    logic alt_ok;
    logic en_a;
    logic en_b;

    // all timing inputs arrive from pins outside the clock domain;
    // vertical sync is filtered inverted so the filter resets to idle
    assign pins = {seg_reset_toggle, seg_reset_sync,
                   frame_count_decode, odd_field, video_in,
                   !vsync_in_n, hsync_in};

    pin_sync #(
        .W(NPIN)
    ) u_sync (
        .hclk(hclk),
        .hresetn(hresetn),
        .pin(pins),
        .level(lvl)
    );

    assign h_s = lvl[0];
    assign vn_s = !lvl[1];
    assign vid_s = lvl[2];
    assign odd_s = lvl[3];
    assign frm_s = lvl[4];
    assign segs_s = lvl[5];
    assign segt_s = lvl[6];

    split_regs u_regs (
        .hclk(hclk),
        .hresetn(hresetn),
        .hsel(hsel),
        .haddr(haddr),
        .htrans(htrans),
        .hwrite(hwrite),
        .hsize(hsize),
        .hwdata(hwdata),
        .hready(hready),
        .hrdata(hrdata),
        .hreadyout(hreadyout),
        .hresp(hresp),
        .status(status),
        .split_en(split_en),
        .interlace_en(interlace_en)
    );

    assign status = {8'h0, frames_q, 4'h0, arm_b_q, arm_a_q,
                     field_odd_q, sel_b_q, 3'h0, line_cnt_q};

    // edge detection on the filtered levels
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            h_prev_q <= 1'b0;
            vn_prev_q <= 1'b1;
        end else begin
            h_prev_q <= h_s;
            vn_prev_q <= vn_s;
        end
    end

    assign line_stb = h_s && !h_prev_q;
    assign vs_fall = !vn_s && vn_prev_q;

    // line counter, cleared by every normal vertical sync
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            line_cnt_q <= '0;
        end else if (vs_fall) begin
            line_cnt_q <= '0;
        end else if (line_stb) begin
            line_cnt_q <= line_cnt_q + 5'h01;
        end
    end

    // shifted syncs fall every 16 lines, first at count eight
    assign sync_slot = split_en && line_stb && !vs_fall &&
                       line_cnt_q[3:0] == SYNC_SLOT_DEC;
    assign fire_b = sync_slot && next_b_q && arm_b_q &&
                    (odd_s || !interlace_en);
    assign fire_a = sync_slot && !next_b_q && arm_a_q;
    assign toggle_hit = split_en && line_stb && !vs_fall &&
                        line_cnt_q == TOGGLE_DEC &&
                        line_cnt_q[0];

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            next_b_q <= 1'b1;
        end else if (vs_fall) begin
            next_b_q <= 1'b1;
        end else if (sync_slot) begin
            next_b_q <= !next_b_q;
        end
    end

    // sync arming: set by vertical sync, cleared by segment decode
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            arm_a_q <= 1'b0;
            arm_b_q <= 1'b0;
        end else if (vs_fall) begin
            arm_a_q <= 1'b1;
            arm_b_q <= 1'b1;
        end else if (segs_s) begin
            arm_a_q <= 1'b0;
            arm_b_q <= 1'b0;
        end
    end

    // a/b video selector
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sel_b_q <= 1'b0;
        end else if (vs_fall) begin
            sel_b_q <= 1'b0;
        end else if (toggle_hit) begin
            sel_b_q <= 1'b1;
        end else if (segt_s) begin
            sel_b_q <= 1'b0;
        end
    end

    // field parity and frame restart
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            field_odd_q <= 1'b1;
        end else if (vs_fall) begin
            if (frm_s && odd_s) begin
                field_odd_q <= 1'b1;
            end else begin
                field_odd_q <= !field_odd_q;
            end
        end
    end

    // a picture is done once the even field has also been scanned
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            picture_done <= 1'b0;
            frames_q <= '0;
        end else begin
            picture_done <= vs_fall && !field_odd_q;
            if (vs_fall && !field_odd_q) begin
                frames_q <= frames_q + 8'h01;
            end
        end
    end

    // vertical sync outputs last one line when split; unsplit, a follows the input and b stays low
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            vsync_out_a <= 1'b0;
            vsync_out_b <= 1'b0;
        end else if (!split_en) begin
            vsync_out_a <= !vn_s;
            vsync_out_b <= 1'b0;
        end else begin
            if (fire_a) begin
                vsync_out_a <= 1'b1;
            end else if (line_stb || vs_fall) begin
                vsync_out_a <= 1'b0;
            end
            if (fire_b) begin
                vsync_out_b <= 1'b1;
            end else if (line_stb || vs_fall) begin
                vsync_out_b <= 1'b0;
            end
        end
    end

    // horizontal sync fanned out inverted to both displays
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hsync_out_a <= 1'b1;
            hsync_out_b <= 1'b1;
        end else begin
            hsync_out_a <= !h_s;
            hsync_out_b <= !h_s;
        end
    end

    // video envelopes: a at 0..14, b at 16..30, slot 15 switches
    assign env_a = line_cnt_q >= VID_A_FIRST &&
                   line_cnt_q <= VID_A_LAST;
    assign env_b = line_cnt_q >= VID_B_FIRST &&
                   line_cnt_q <= VID_B_LAST;
    // non-interlaced gating uses every other line only
    assign alt_ok = interlace_en || !line_cnt_q[0];
    assign en_a = split_en ? (!sel_b_q && env_a && alt_ok)
                           : 1'b1;
    assign en_b = split_en && sel_b_q && env_b && alt_ok;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            video_out_a <= 1'b0;
            video_out_b <= 1'b0;
        end else begin
            video_out_a <= vid_s && en_a;
            video_out_b <= vid_s && en_b;
        end
    end

    // checks
    sequence s_vs_edge;
        vs_fall;
    endsequence

    sequence s_cleared;
        line_cnt_q == '0 && !sel_b_q && arm_a_q && arm_b_q;
    endsequence

    chk_vs_clear: assert property (
        @(posedge hclk) disable iff (!hresetn)
        s_vs_edge |=> s_cleared)
        else $error("vertical sync did not clear and arm");

    chk_sync_b_eight: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (split_en && line_stb && line_cnt_q == SYNC_B_DEC && next_b_q
         && arm_b_q && odd_s && !vs_fall)
        |=> vsync_out_b && line_cnt_q == 5'h08)
        else $error("no b sync at count eight");

    chk_sync_a_24: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (split_en && line_stb && line_cnt_q == SYNC_A_DEC && !next_b_q
         && arm_a_q && !vs_fall)
        |=> vsync_out_a && line_cnt_q == 5'h18)
        else $error("no a sync at count twenty four");

    chk_toggle_16: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (toggle_hit && interlace_en) |=> sel_b_q && line_cnt_q == 5'h10)
        else $error("selector did not move to b at sixteen");

    chk_video_excl: assert property (
        @(posedge hclk) disable iff (!hresetn)
        !(video_out_a && video_out_b))
        else $error("video driven to both displays");

    chk_hsync_fan: assert property (
        @(posedge hclk) disable iff (!hresetn)
        ##1 hsync_out_a == !$past(h_s) && hsync_out_b == hsync_out_a)
        else $error("horizontal sync not fanned out inverted");

    chk_b_envelope: assert property (
        @(posedge hclk) disable iff (!hresetn)
        video_out_b |-> $past(line_cnt_q) >= VID_B_FIRST &&
                        $past(line_cnt_q) <= VID_B_LAST)
        else $error("b video outside its 15 line envelope");

    chk_single_screen: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (!split_en ##1 !split_en) |-> !video_out_b && !vsync_out_b &&
                                      video_out_a == $past(vid_s))
        else $error("single screen mode leaked to b");

    chk_video_gate: assert property (
        @(posedge hclk) disable iff (!hresetn)
        video_out_a |-> $past(vid_s) && !$past(sel_b_q && split_en))
        else $error("a video without input or while b selected");

    chk_return_a: assert property (
        @(posedge hclk) disable iff (!hresetn)
        s_vs_edge |=> !sel_b_q ##1 !video_out_b)
        else $error("vertical sync did not return video to a");

    chk_frame_done: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (vs_fall && !field_odd_q) |=> picture_done && field_odd_q)
        else $error("picture not marked done after even field");
endmodule : dual_display_sync_splitter

//--- include/dds_pkg.sv
// constants shared by the display sync splitter and its register slave
package dds_pkg;
    localparam int CNT_W = 5;
    localparam int SYNC_STAGES = 3;
    // line counts within one field
    localparam logic [4:0] NORMAL_LINES = 5'h1f;
    localparam logic [4:0] SPLIT_LINES = 5'h0f;
    localparam logic [3:0] SYNC_SLOT_DEC = 4'h7;
    localparam logic [4:0] SYNC_B_DEC = 5'h07;
    localparam logic [4:0] TOGGLE_DEC = 5'h0f;
    localparam logic [4:0] SYNC_A_DEC = 5'h17;
    localparam logic [4:0] VID_A_FIRST = 5'h00;
    localparam logic [4:0] VID_A_LAST = 5'h0e;
    localparam logic [4:0] VID_B_FIRST = 5'h10;
    localparam logic [4:0] VID_B_LAST = 5'h1e;
    // two fields make one frame of 62 lines
    localparam logic [5:0] FRAME_LINES = 6'h3e;
    // register map, byte addresses
    localparam logic [31:0] CTRL_OFF = 32'h0000_0000;
    localparam logic [31:0] STAT_OFF = 32'h0000_0004;
    localparam int CTRL_SPLIT_BIT = 0;
    localparam int CTRL_ILACE_BIT = 1;
    localparam logic [1:0] CTRL_RST = 2'h3;
    localparam int STAT_CNT_LSB = 0;
    localparam int STAT_SEL_BIT = 8;
    localparam int STAT_ODD_BIT = 9;
    localparam int STAT_ARMA_BIT = 10;
    localparam int STAT_ARMB_BIT = 11;
    localparam int STAT_FRM_LSB = 16;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic HRESP_OKAY = 1'b0;
endpackage : dds_pkg

//--- design/pin_sync.sv
// three-stage pin synchroniser with agreement filter
`timescale 1ns/10ps
module pin_sync #(
    parameter int W = 1
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic [W-1:0] pin,
    output logic [W-1:0] level
);
    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;
    logic [W-1:0] s3_q;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
        end else begin
            s1_q <= pin;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // a change counts once stages two and three agree
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            level <= '0;
        end else begin
            for (int i = 0; i < W; i++) begin
                if (s2_q[i] == s3_q[i]) begin
                    level[i] <= s3_q[i];
                end
            end
        end
    end
endmodule : pin_sync

//--- design/split_regs.sv
// ahb-lite slave holding the control and status words
`timescale 1ns/10ps
module split_regs
    import dds_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic [31:0] status,
    output logic split_en,
    output logic interlace_en
);
    logic wr_pend_q;
    logic [31:0] waddr_q;
    logic take;

    assign take = hsel && hready && htrans == HTRANS_NONSEQ;
    // zero wait states, always okay
    assign hreadyout = 1'b1;
    assign hresp = HRESP_OKAY;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q <= 1'b0;
            waddr_q <= '0;
        end else begin
            wr_pend_q <= take && hwrite && hsize == 3'h2;
            waddr_q <= haddr;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            split_en <= CTRL_RST[CTRL_SPLIT_BIT];
            interlace_en <= CTRL_RST[CTRL_ILACE_BIT];
        end else if (wr_pend_q && waddr_q == CTRL_OFF) begin
            split_en <= hwdata[CTRL_SPLIT_BIT];
            interlace_en <= hwdata[CTRL_ILACE_BIT];
        end
    end

    // read data loaded at the address phase, stands in the data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= '0;
        end else if (take && !hwrite) begin
            if (haddr == CTRL_OFF) begin
                hrdata <= {30'h0, interlace_en, split_en};
            end else if (haddr == STAT_OFF) begin
                hrdata <= status;
            end else begin
                hrdata <= '0;
            end
        end
    end
endmodule : split_regs

//--- test/raster_timing_model.sv
// raster timing source that also notes what each display should show
`timescale 1ns/10ps
module raster_timing_model (
    input wire logic hclk,
    output logic hsync_in,
    output logic vsync_in_n,
    output logic video_in,
    output logic odd_field,
    output logic frame_count_decode,
    output logic seg_reset_sync,
    output logic seg_reset_toggle,
    output logic chk,
    output logic [4:0] exp_bits
);
    initial begin
        hsync_in = 1'b0;
        vsync_in_n = 1'b1;
        video_in = 1'b0;
        odd_field = 1'b0;
        frame_count_decode = 1'b0;
        seg_reset_sync = 1'b0;
        seg_reset_toggle = 1'b0;
        chk = 1'b0;
        exp_bits = 5'h00;
    end

    // line 0 carries the vertical sync, lines 1..30 open with an hsync edge
    // seg: 1 clears sync arms at line 4, 2 clears the selector at line 20
    task automatic run_field(input logic odd, split, ilace, input int seg);
        logic vb, lv, a_on, b_on, sa, sb;
        sa = seg != 1;
        sb = (odd || !ilace) && seg != 1;
        for (int ln = 0; ln < 31; ln++) begin
            vb = 1'($urandom);
            lv = !split || ilace || (ln % 2 == 0);
            a_on = !split || ln <= 14;
            b_on = split && ln >= 16 && !(seg == 2 && ln >= 21);
            for (int c = 0; c < 24; c++) begin
                @(posedge hclk);
                hsync_in <= ln > 0 && c < 8;
                vsync_in_n <= !(ln == 0 && c < 8);
                frame_count_decode <= odd && ln == 0 && c < 8;
                odd_field <= odd;
                video_in <= vb && c >= 8 && c < 16;
                seg_reset_sync <= seg == 1 && ln == 4 && c >= 16;
                seg_reset_toggle <= seg == 2 && ln == 20 && c >= 16;
                chk <= c == 6 || c == 15;
                exp_bits[2] <= split && ln == 8 && sb;
                if (c == 6) begin
                    exp_bits[4] <= ln == 0;
                    exp_bits[3] <= split ? (ln == 24 && sa) : ln == 0;
                    exp_bits[1:0] <= 2'h0;
                end else begin
                    exp_bits[4] <= 1'b1;
                    exp_bits[3] <= split && ln == 24 && sa;
                    exp_bits[1] <= vb && lv && a_on;
                    exp_bits[0] <= vb && lv && b_on;
                end
            end
        end
    endtask : run_field
endmodule : raster_timing_model

//--- test/dual_display_sync_splitter_tb.sv
// self-checking bench for the display sync splitter
`timescale 1ns/10ps
module dual_display_sync_splitter_tb;
    import dds_pkg::*;
    logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic hsync_in, vsync_in_n, video_in, odd_field, frame_count_decode;
    logic seg_reset_sync, seg_reset_toggle, chk, picture_done;
    logic hsync_out_a, hsync_out_b, vsync_out_a, vsync_out_b;
    logic video_out_a, video_out_b;
    logic [4:0] exp_bits, e;
    logic [4:0] notes[$];
    int n_tests = 0;
    int n_mismatch = 0;
    int n_pic = 0;

    assign hready = hreadyout;

    dual_display_sync_splitter dut (.hclk(hclk), .hresetn(hresetn),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .hsync_in(hsync_in),
        .vsync_in_n(vsync_in_n), .video_in(video_in), .odd_field(odd_field),
        .frame_count_decode(frame_count_decode),
        .seg_reset_sync(seg_reset_sync), .seg_reset_toggle(seg_reset_toggle),
        .hsync_out_a(hsync_out_a), .hsync_out_b(hsync_out_b),
        .vsync_out_a(vsync_out_a), .vsync_out_b(vsync_out_b),
        .video_out_a(video_out_a), .video_out_b(video_out_b),
        .picture_done(picture_done));

    raster_timing_model rtu (.hclk(hclk), .hsync_in(hsync_in),
        .vsync_in_n(vsync_in_n), .video_in(video_in), .odd_field(odd_field),
        .frame_count_decode(frame_count_decode),
        .seg_reset_sync(seg_reset_sync), .seg_reset_toggle(seg_reset_toggle),
        .chk(chk), .exp_bits(exp_bits));

    initial begin
        hclk = 1'b0;
        forever #2 hclk = ~hclk;
    end

    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : wrap_up

    task automatic check(input string what, input logic [31:0] seen, ex);
        n_tests++;
        if (seen !== ex) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", what, ex, seen);
        end
    endtask : check

    // one single-word transfer; waits on hready in both phases
    task automatic bus(input logic w, input logic [31:0] a, wd);
        int i;
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= HTRANS_NONSEQ;
        hwrite <= w;
        hsize <= 3'h2;
        i = 0;
        do begin
            @(posedge hclk);
            i++;
        end while (hready !== 1'b1 && i < 64);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do begin
            @(posedge hclk);
            i++;
        end while (hready !== 1'b1 && i < 64);
        rd = hrdata;
        check("hresp", hresp, HRESP_OKAY);
        if (i >= 64) begin
            n_mismatch++;
            $display("Error bus wait expected hready seen none");
            wrap_up();
        end
    endtask : bus

    // the notes are taken off in the order the timing source wrote them
    always @(negedge hclk) begin
        if (chk === 1'b1) begin
            notes.push_back(exp_bits);
        end
        if (notes.size() > 0) begin
            e = notes.pop_front();
            check("hsync_out_a", hsync_out_a, e[4]);
            check("hsync_out_b", hsync_out_b, e[4]);
            check("vsync_out_a", vsync_out_a, e[3]);
            check("vsync_out_b", vsync_out_b, e[2]);
            check("video_out_a", video_out_a, e[1]);
            check("video_out_b", video_out_b, e[0]);
        end
        if (hresetn === 1'b1) begin
            check("video overlap", video_out_a & video_out_b, 1'b0);
            if (picture_done === 1'b1) begin
                n_pic++;
            end
        end
    end

    initial begin
        repeat (100000) @(posedge hclk);
        n_mismatch++;
        $display("Error run length expected end seen timeout");
        wrap_up();
    end

    initial begin
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0000_0000;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0000_0000;
        void'($urandom(2917));
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        bus(1'b0, CTRL_OFF, 32'h0);
        check("ctrl reset", rd, {30'h0, CTRL_RST});
        bus(1'b0, 32'h0000_0008, 32'h0);
        check("unmapped read", rd, 32'h0);
        rtu.run_field(1'b1, 1'b1, 1'b1, 0);
        rtu.run_field(1'b0, 1'b1, 1'b1, 0);
        $display("split interlace fields done");
        rtu.run_field(1'b1, 1'b1, 1'b1, 1);
        rtu.run_field(1'b0, 1'b1, 1'b1, 2);
        $display("segment reset fields done");
        bus(1'b1, CTRL_OFF, 32'h2);
        bus(1'b0, CTRL_OFF, 32'h0);
        check("ctrl single", rd, 32'h2);
        rtu.run_field(1'b1, 1'b0, 1'b1, 0);
        rtu.run_field(1'b0, 1'b0, 1'b1, 0);
        $display("single screen fields done");
        bus(1'b1, CTRL_OFF, 32'h1);
        bus(1'b0, CTRL_OFF, 32'h0);
        check("ctrl non interlace", rd, 32'h1);
        rtu.run_field(1'b1, 1'b1, 1'b0, 0);
        rtu.run_field(1'b0, 1'b1, 1'b0, 0);
        rtu.run_field(1'b1, 1'b1, 1'b0, 0);
        repeat (8) @(posedge hclk);
        check("picture pulses", n_pic, 32'd4);
        bus(1'b0, STAT_OFF, 32'h0);
        check("picture counter", rd[23:16], 8'h04);
        $display("non interlace fields done");
        wrap_up();
    end
endmodule : dual_display_sync_splitter_tb
